// *** src/dsf_status_flags.sv ***
////////////////////////////////////////////////////////////////////////////////
// Purpose: Driver status flag word with latched faults and bridge enable.
// Assumes: Analog front ends and the step pin are asynchronous; config is local.
// Notes: Writes to the status word have no path into this block.
////////////////////////////////////////////////////////////////////////////////
// Overview of operation
// - Status flags and current level read back as one word at address 0x6F.
// - Bit 31 sets after 2^20 clocks without step pulse, clears on stepping.
// - Bit 30 is one in quiet voltage mode, zero in dynamic current mode.
// - Bits 20 to 16 show the current scaling value presently applied.
// - Bits 11 to 8 mirror the 157, 150, 143 and 120 degree comparators.
// - Bits 7 and 6 show open load on phases B and A, no protective action.
// - Low-side short on phase B or A sets bit 5 or 4, disables driver.
// - Short to ground on phase B or A sets bit 3 or 2, disables driver.
// - Separate short flags are kept for each chopper mode.
// - Bit 1 sets at the selected shutdown limit, shared by both bridges.
// - Bit 0 sets above the selected pre-warning threshold, shared flag.
`timescale 1ns/10ps

module dsf_status_flags #(
  parameter int unsigned STST_CYCLES = dsf_pkg::STST_CYCLES_DEF
) (
  input wire logic SYS_CLK_I,
  input wire logic RESET_N_I,
  input wire logic STEP_I,
  input wire logic ENABLE_N_PIN_I,
  input wire logic [3:0] THERMAL_CMP_I,
  input wire logic [1:0] OPEN_LOAD_I,
  input wire logic [3:0] SHORT_DET_I,
  input wire logic QUIET_MODE_I,
  input wire logic [dsf_pkg::CS_W-1:0] CS_ACTUAL_I,
  input wire logic [dsf_pkg::OFF_TIME_W-1:0] CHOPPER_OFF_TIME_I,
  input wire logic TEMP_SEL_I,
  input wire logic REG_RD_I,
  input wire logic [6:0] REG_ADDR_I,
  output logic [31:0] REG_RDATA_O,
  output logic REG_RVALID_O,
  output logic DRIVER_EN_O
);

  localparam int CW = $clog2(STST_CYCLES + 1);
  localparam logic [CW-1:0] CNT_MAX = CW'(STST_CYCLES);

  logic [dsf_pkg::SYNC_W-1:0] sync1_r;
  logic [dsf_pkg::SYNC_W-1:0] sync2_r;
  logic step_s;
  logic step_d_r;
  logic step_edge;
  logic enable_n_s;
  logic [3:0] therm_s;
  logic [1:0] open_s;
  logic [3:0] short_det_s;
  logic drv_off;
  logic [CW-1:0] stst_cnt_r;
  logic stst_r;
  logic [3:0] short_r [2];
  logic [3:0] short_cur;
  logic shutdown_s;
  logic pw_s;
  logic shutdown_lock_r;
  logic [31:0] status_r;
  logic [31:0] status_nxt;
  dsf_pkg::dsf_mode_t mode;

  //////////////////////////////////////////////////////////////////////////////
  // Two-stage synchronisers for the pin and analog front-end inputs.
  always_ff @(posedge SYS_CLK_I) begin
    if (!RESET_N_I) begin
      sync1_r <= dsf_pkg::SYNC_RST;
      sync2_r <= dsf_pkg::SYNC_RST;
    end else begin
      sync1_r <= {STEP_I, ENABLE_N_PIN_I, THERMAL_CMP_I, OPEN_LOAD_I, SHORT_DET_I};
      sync2_r <= sync1_r;
    end
  end

  assign step_s = sync2_r[11];
  assign enable_n_s = sync2_r[10];
  assign therm_s = sync2_r[9:6];
  assign open_s = sync2_r[5:4];
  assign short_det_s = sync2_r[3:0];
  assign mode = QUIET_MODE_I ? dsf_pkg::DSF_MODE_QUIET : dsf_pkg::DSF_MODE_DYNAMIC;
  assign drv_off = enable_n_s | (CHOPPER_OFF_TIME_I == '0);

  //////////////////////////////////////////////////////////////////////////////
  // Standstill detection.
  always_ff @(posedge SYS_CLK_I) begin
    if (!RESET_N_I) begin
      step_d_r <= 1'b0;
    end else begin
      step_d_r <= step_s;
    end
  end

  assign step_edge = step_s & ~step_d_r;

  always_ff @(posedge SYS_CLK_I) begin
    if (!RESET_N_I) begin
      stst_cnt_r <= '0;
      stst_r <= 1'b0;
    end else if (step_edge) begin
      stst_cnt_r <= '0;
      stst_r <= 1'b0;
    end else if (stst_cnt_r != CNT_MAX) begin
      stst_cnt_r <= stst_cnt_r + 1'b1;
      stst_r <= (stst_cnt_r == CNT_MAX - 1'b1);
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Latched short flags, one set per chopper mode; a new detection wins.
  generate
    for (genvar m = 0; m < 2; m++) begin : g_short
      always_ff @(posedge SYS_CLK_I) begin
        if (!RESET_N_I) begin
          short_r[m] <= '0;
        end else begin
          short_r[m] <= (drv_off ? 4'h0 : short_r[m])
                        | (short_det_s & {4{mode == dsf_pkg::dsf_mode_t'(m)}});
        end
      end
    end
  endgenerate

  assign short_cur = short_r[mode];

  //////////////////////////////////////////////////////////////////////////////
  // Over-temperature selection and shutdown lock.
  assign shutdown_s = TEMP_SEL_I ? therm_s[3] : therm_s[1];
  assign pw_s = TEMP_SEL_I ? therm_s[1] : therm_s[0];

  always_ff @(posedge SYS_CLK_I) begin
    if (!RESET_N_I) begin
      shutdown_lock_r <= 1'b0;
    end else begin
      shutdown_lock_r <= shutdown_s | (shutdown_lock_r & pw_s);
    end
  end

  always_ff @(posedge SYS_CLK_I) begin
    if (!RESET_N_I) begin
      DRIVER_EN_O <= 1'b0;
    end else begin
      DRIVER_EN_O <= ~drv_off & ~(|short_r[0]) & ~(|short_r[1])
                     & ~shutdown_lock_r & ~shutdown_s;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Status word assembly and read port.
  always_comb begin
    status_nxt = dsf_pkg::STATUS_RST;
    status_nxt[dsf_pkg::BIT_STST] = stst_r;
    status_nxt[dsf_pkg::BIT_QUIET] = (mode == dsf_pkg::DSF_MODE_QUIET);
    status_nxt[dsf_pkg::BIT_CS_LO +: dsf_pkg::CS_W] = CS_ACTUAL_I;
    status_nxt[dsf_pkg::BIT_THERM_LO +: 4] = therm_s;
    status_nxt[dsf_pkg::BIT_OPEN_LO +: 2] = open_s;
    status_nxt[dsf_pkg::BIT_SHORT_LO +: 4] = short_cur;
    status_nxt[dsf_pkg::BIT_SHUTDOWN] = shutdown_s;
    status_nxt[dsf_pkg::BIT_OTPW] = pw_s;
  end

  always_ff @(posedge SYS_CLK_I) begin
    if (!RESET_N_I) begin
      status_r <= dsf_pkg::STATUS_RST;
    end else begin
      status_r <= status_nxt;
    end
  end

  always_ff @(posedge SYS_CLK_I) begin
    if (!RESET_N_I) begin
      REG_RDATA_O <= '0;
      REG_RVALID_O <= 1'b0;
    end else begin
      REG_RVALID_O <= REG_RD_I;
      REG_RDATA_O <= (REG_RD_I && REG_ADDR_I == dsf_pkg::STATUS_ADDR) ? status_r : '0;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Checks.
  default clocking cb @(posedge SYS_CLK_I); endclocking
  default disable iff (!RESET_N_I);

  sequence s_status_read;
    REG_RD_I && (REG_ADDR_I == dsf_pkg::STATUS_ADDR);
  endsequence

  sequence s_short_hit;
    (|short_det_s) && !drv_off;
  endsequence

  chk_read_word: assert property (
    s_status_read |=> REG_RVALID_O && (REG_RDATA_O == $past(status_r)))
    else $error("Status read returned wrong word.");

  chk_stst_set: assert property (
    $rose(stst_r) |-> (stst_cnt_r == CNT_MAX) && !$past(step_edge))
    else $error("Standstill set before full idle count.");

  chk_stst_clear: assert property (
    step_edge |=> !stst_r ##1 !status_r[dsf_pkg::BIT_STST])
    else $error("Standstill not cleared by step.");

  chk_mode_bit: assert property (
    ##1 status_r[dsf_pkg::BIT_QUIET] == $past(QUIET_MODE_I))
    else $error("Chopper mode bit wrong.");

  chk_cs_thermal: assert property (
    ##1 (status_r[20:16] == $past(CS_ACTUAL_I)) && (status_r[11:6] == $past({therm_s, open_s})))
    else $error("Current scale or comparator bits wrong.");

  chk_short_disable: assert property (
    s_short_hit ##1 !drv_off |-> ##1 !DRIVER_EN_O && (|short_r[0] || |short_r[1]))
    else $error("Short did not latch and disable driver.");

  chk_short_hold: assert property (
    !drv_off |=> ((short_r[0] & $past(short_r[0])) == $past(short_r[0]))
      && ((short_r[1] & $past(short_r[1])) == $past(short_r[1])))
    else $error("Short flag lost while driver enabled.");

  chk_short_clear: assert property (
    drv_off && !(|short_det_s) |=> (short_r[0] == 4'h0) && (short_r[1] == 4'h0))
    else $error("Short flags not cleared while driver disabled.");

  chk_mode_separate: assert property (
    (mode == dsf_pkg::DSF_MODE_DYNAMIC) && !drv_off |=> short_r[1] == $past(short_r[1]))
    else $error("Quiet-mode short flags changed in dynamic mode.");

  chk_quiet_separate: assert property (
    (mode == dsf_pkg::DSF_MODE_QUIET) && !drv_off |=> short_r[0] == $past(short_r[0]))
    else $error("Dynamic-mode short flags changed in quiet mode.");

  chk_temp_flags: assert property (
    ##1 (status_r[1:0] == $past({shutdown_s, pw_s})))
    else $error("Temperature flags wrong.");

  chk_shutdown_lock: assert property (
    shutdown_lock_r && pw_s |=> shutdown_lock_r ##1 !DRIVER_EN_O)
    else $error("Bridges re-enabled before pre-warning cleared.");

  chk_reserved_zero: assert property (
    (status_r & dsf_pkg::RESERVED_MASK) == 32'h0000_0000)
    else $error("Reserved status bits not zero.");

endmodule // dsf_status_flags

// *** src/dsf_pkg.sv ***
////////////////////////////////////////////////////////////////////////////////
// Purpose: Constants for the driver status flag word.
// Assumes: One 32-bit read-only word, one 10 MHz clock.
// Notes: Bit positions are the low bit of each field.
////////////////////////////////////////////////////////////////////////////////
package dsf_pkg;

  localparam logic [6:0] STATUS_ADDR = 7'h6f;
  localparam int unsigned STST_CYCLES_DEF = 1048576;
  localparam int unsigned CLK_PERIOD_NS = 100;

  localparam int unsigned OFF_TIME_W = 4;
  localparam int unsigned CS_W = 5;
  localparam int unsigned SYNC_W = 12;
  // The enable pin stage resets to its disabled level so the bridges stay off after reset.
  localparam logic [SYNC_W-1:0] SYNC_RST = 12'h400;

  localparam int unsigned BIT_STST = 31;
  localparam int unsigned BIT_QUIET = 30;
  localparam int unsigned BIT_CS_LO = 16;
  localparam int unsigned BIT_THERM_LO = 8;
  localparam int unsigned BIT_OPEN_LO = 6;
  localparam int unsigned BIT_SHORT_LO = 2;
  localparam int unsigned BIT_SHUTDOWN = 1;
  localparam int unsigned BIT_OTPW = 0;

  localparam logic [31:0] STATUS_RST = 32'h0000_0000;
  localparam logic [31:0] RESERVED_MASK = 32'h3fe0_f000;

  typedef enum logic {
    DSF_MODE_DYNAMIC,
    DSF_MODE_QUIET
  } dsf_mode_t;

endpackage

// *** sim/dsf_host_model.sv ***
////////////////////////////////////////////////////////////////////////////////
// Purpose: Host side of the status register read transport.
// Assumes: One read in flight, answer within a few cycles.
// Notes: Open-load bits are handed back raw; judging them is up to the caller.
////////////////////////////////////////////////////////////////////////////////
`timescale 1ns/10ps

module dsf_host_model (
  input wire logic clk_i,
  input wire logic rvalid_i,
  input wire logic [31:0] rdata_i,
  output logic rd_o,
  output logic [6:0] addr_o
);
  initial begin
    rd_o = 1'b0;
    addr_o = 7'h00;
  end

  // Issues one read strobe and waits a bounded time for the answer.
  task automatic read(input logic [6:0] a, output logic [31:0] d, output logic ok);
    int n;
    ok = 1'b0;
    d = 32'h0000_0000;
    @(posedge clk_i);
    rd_o <= 1'b1;
    addr_o <= a;
    @(posedge clk_i);
    rd_o <= 1'b0;
    for (n = 0; n < 4 && ok == 1'b0; n++) begin
      @(posedge clk_i);
      if (rvalid_i === 1'b1) begin
        d = rdata_i;
        ok = 1'b1;
      end
    end
  endtask
endmodule // dsf_host_model

// *** sim/tb.sv ***
////////////////////////////////////////////////////////////////////////////////
// Purpose: Self-checking bench for the driver status flag word.
// Assumes: Standstill count shortened to 16 cycles.
// Notes: Rows are packed {quiet, scale, comparators, open load, select}.
////////////////////////////////////////////////////////////////////////////////
`timescale 1ns/10ps

module tb;
  localparam logic [6:0] ADDR = dsf_pkg::STATUS_ADDR;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic step = 1'b0;
  logic enable_n = 1'b0;
  logic [3:0] therm = 4'h0;
  logic [1:0] ol = 2'h0;
  logic [3:0] sh = 4'h0;
  logic quiet = 1'b0;
  logic [4:0] cs = 5'h00;
  logic [3:0] off_time = 4'h5;
  logic sel = 1'b0;
  logic rd;
  logic [6:0] addr;
  logic [31:0] rdata;
  logic rvalid;
  logic en;
  logic [31:0] w;
  logic ok;
  int fail_count = 0;
  int checks_done = 0;
  logic [12:0] rows [6] = '{13'h1f84, 13'h000a, 13'h151e, 13'h0ac1, 13'h18b1, 13'h0000};

  always #(dsf_pkg::CLK_PERIOD_NS / 2) clk = ~clk;

  dsf_status_flags #(.STST_CYCLES(16)) dsf_status_flags_inst (
    .SYS_CLK_I(clk), .RESET_N_I(rst_n), .STEP_I(step), .ENABLE_N_PIN_I(enable_n),
    .THERMAL_CMP_I(therm), .OPEN_LOAD_I(ol), .SHORT_DET_I(sh), .QUIET_MODE_I(quiet),
    .CS_ACTUAL_I(cs), .CHOPPER_OFF_TIME_I(off_time), .TEMP_SEL_I(sel), .REG_RD_I(rd),
    .REG_ADDR_I(addr), .REG_RDATA_O(rdata), .REG_RVALID_O(rvalid), .DRIVER_EN_O(en));

  dsf_host_model dsf_host_model_inst (.clk_i(clk), .rvalid_i(rvalid), .rdata_i(rdata),
    .rd_o(rd), .addr_o(addr));

  function automatic logic [31:0] exp_word(input logic [12:0] r, input logic s);
    logic sd;
    logic pw;
    sd = r[0] ? r[6] : r[4];
    pw = r[0] ? r[4] : r[3];
    return {s, r[12], 9'h000, r[11:7], 4'h0, r[6:3], r[2:1], 4'h0, sd, pw};
  endfunction

  task automatic summarize();
    $display("checks %0d errors %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    checks_done++;
    if (got !== exp) begin
      $display("ERROR %0t %s", $time, m);
      fail_count++;
    end
  endtask

  task automatic rdw(input logic [6:0] a);
    dsf_host_model_inst.read(a, w, ok);
    chk({31'h0, ok}, 32'h1, "read not answered");
    if (ok !== 1'b1) summarize();
  endtask

  task automatic wt(input int n);
    repeat (n) @(posedge clk);
  endtask

  initial begin
    wt(8);
    chk(rdata | {31'h0, rvalid}, 32'h0, "outputs during reset");
    rst_n <= 1'b1;
    repeat (3) begin
      @(posedge clk) step <= 1'b1;
      wt(3);
      step <= 1'b0;
      wt(3);
    end
    rdw(ADDR);
    chk(w & 32'h8000_0000, 32'h0, "standstill while stepping");
    wt(25);
    rdw(ADDR);
    chk(w & 32'h8000_0000, 32'h8000_0000, "standstill missing");
    for (int i = 0; i < 6; i++) begin
      @(posedge clk);
      quiet <= rows[i][12];
      cs <= rows[i][11:7];
      therm <= rows[i][6:3];
      ol <= rows[i][2:1];
      sel <= rows[i][0];
      wt(5);
      rdw(ADDR);
      chk(w, exp_word(rows[i], 1'b1), "status word");
    end
    rdw(7'h6e);
    chk(w, 32'h0, "unmapped read");
    @(posedge clk) therm <= 4'h3;
    wt(5);
    chk({31'h0, en}, 32'h0, "bridge on in shutdown");
    therm <= 4'h1;
    wt(5);
    chk({31'h0, en}, 32'h0, "bridge on before cooling");
    therm <= 4'h0;
    wt(5);
    chk({31'h0, en}, 32'h1, "bridge off after cooling");
    for (int i = 0; i < 4; i++) begin
      @(posedge clk) sh <= 4'h1 << i;
      wt(2);
      sh <= 4'h0;
      wt(5);
      rdw(ADDR);
      chk({26'h0, w[5:2], en, 1'b0}, {26'h0, 4'h1 << i, 2'b00}, "short latch");
      @(posedge clk) quiet <= 1'b1;
      wt(3);
      rdw(ADDR);
      chk(w & 32'h3c, 32'h0, "other mode flags");
      @(posedge clk) quiet <= 1'b0;
      if (i[0]) enable_n <= 1'b1;
      else off_time <= 4'h0;
      wt(5);
      enable_n <= 1'b0;
      off_time <= 4'h5;
      wt(5);
      rdw(ADDR);
      chk((w & 32'h3c) | {31'h0, ~en}, 32'h0, "short clear");
    end
    @(posedge clk) quiet <= 1'b1;
    sh <= 4'h4;
    wt(2);
    sh <= 4'h0;
    wt(5);
    rdw(ADDR);
    chk(w & 32'h3c, 32'h10, "quiet mode short");
    @(posedge clk) quiet <= 1'b0;
    wt(2);
    rdw(ADDR);
    chk({27'h0, w[5:2], en}, 32'h0, "quiet short leaked");
    rst_n <= 1'b0;
    wt(3);
    chk(rdata | {30'h0, rvalid, en}, 32'h0, "outputs in mid-run reset");
    rst_n <= 1'b1;
    rdw(ADDR);
    chk(w, 32'h0, "word after reset");
    wt(2);
    chk({31'h0, en}, 32'h1, "bridge off after reset");
    summarize();
  end
endmodule // tb
